// ===== rtl/jtb_pkg.sv
package jtb_pkg;

	// ==========================================================================
	// Instruction codes and register sizes
	// ==========================================================================
	localparam int        IR_W         = 3;
	localparam logic [2:0] INS_EXTEST   = 3'h0;
	localparam logic [2:0] INS_IDCODE   = 3'h1;
	localparam logic [2:0] INS_SAMPLE_Z = 3'h2;
	localparam logic [2:0] INS_SAMPLE   = 3'h4;
	localparam logic [2:0] INS_BYPASS   = 3'h7;
	localparam logic [2:0] IR_RESET_VAL = INS_IDCODE;
	localparam logic [1:0] IR_CAPTURE   = 2'h1;
	localparam int        ID_W         = 32;
	localparam int        BSR_W        = 129;
	localparam int        RING_W       = 128;
	localparam int        INT_CELL     = 128;

	// Identity value is arbitrary; bit 0 is the mandatory start bit.
	localparam logic [31:0] ID_VALUE    = 32'h0000_0A5B;

	// ==========================================================================
	// Ring layout: low bits are read data, then valid, echo clock pair
	// ==========================================================================
	localparam int        Q_W          = 36;
	localparam int        Q_LSB        = 0;
	localparam int        VLD_BIT      = 36;
	localparam int        ECHO_BIT     = 37;
	localparam int        ECHON_BIT    = 38;
	localparam int        OUT_W        = 39;

	// ==========================================================================
	// Link timing
	// ==========================================================================
	localparam int        CLK_NS       = 50;
	localparam int        SYNC_STAGES  = 2;
	localparam int        TLR_ONES     = 5;

	// ==========================================================================
	// Controller states, one-hot
	// ==========================================================================
	typedef enum logic [15:0] {
		ST_TLR   = 16'h0001,
		ST_RTI   = 16'h0002,
		ST_SELDR = 16'h0004,
		ST_CAPDR = 16'h0008,
		ST_SHDR  = 16'h0010,
		ST_EX1DR = 16'h0020,
		ST_PSDR  = 16'h0040,
		ST_EX2DR = 16'h0080,
		ST_UPDR  = 16'h0100,
		ST_SELIR = 16'h0200,
		ST_CAPIR = 16'h0400,
		ST_SHIR  = 16'h0800,
		ST_EX1IR = 16'h1000,
		ST_PSIR  = 16'h2000,
		ST_EX2IR = 16'h4000,
		ST_UPIR  = 16'h8000
	} jtb_state_t;

endpackage : jtb_pkg

// ===== rtl/jtb_sync.sv
`timescale 1ns/100ps
`default_nettype none

// ============================================================================
// Two-flop synchroniser with rise and fall detection on the settled level
// ============================================================================
module jtb_sync
	import jtb_pkg::*;
(
	// Clock and reset
	input  wire logic core_clk,
	input  wire logic resetn,
	// Asynchronous level in
	input  wire logic pin_in,
	// Synchronised level and edges
	output logic      level,
	output logic      rise,
	output logic      fall
);

	typedef struct packed {
		logic meta;
		logic sync;
		logic prev;
	} jtb_sync_t;

	jtb_sync_t s_r;
	jtb_sync_t s_nxt;

	always_comb begin
		s_nxt      = s_r;
		s_nxt.meta = pin_in;
		s_nxt.sync = s_r.meta;
		s_nxt.prev = s_r.sync;
	end

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign level = s_r.sync;
	assign rise  = s_r.sync & ~s_r.prev;
	assign fall  = ~s_r.sync & s_r.prev;

endmodule : jtb_sync

`default_nettype wire

// ===== rtl/jtb_tap.sv
`timescale 1ns/100ps
`default_nettype none

module jtb_tap
	import jtb_pkg::*;
(
	// Clock and reset
	input  wire logic               core_clk,
	input  wire logic               resetn,
	// Test port pins
	input  wire logic               test_clk,
	input  wire logic               test_mode,
	input  wire logic               test_din,
	output logic                    test_dout,
	output logic                    test_dout_oe,
	// Memory I/O ring
	input  wire logic [RING_W-1:0]  ring_in,
	input  wire logic [Q_W-1:0]     core_read_data,
	input  wire logic               core_read_data_oe,
	input  wire logic               core_read_valid,
	input  wire logic               core_echo_clock,
	input  wire logic               core_echo_clock_n,
	// Pins toward the board
	output logic [Q_W-1:0]          read_data_output,
	output logic                    read_data_oe,
	output logic                    read_valid_output,
	output logic                    echo_clock_output,
	output logic                    echo_clock_output_n,
	output logic                    on_die_termination_en,
	// Status
	output logic [IR_W-1:0]         test_instruction_register,
	output logic                    test_reset_state
);

	// ========================================================================
	// Synchronised test pins
	// ========================================================================
	logic tck_rise;
	logic tck_fall;
	logic tms_s;
	logic tdi_s;

	jtb_sync u_sync_tck (
		.core_clk (core_clk),
		.resetn   (resetn),
		.pin_in   (test_clk),
		.level    (),
		.rise     (tck_rise),
		.fall     (tck_fall)
	);

	jtb_sync u_sync_tms (
		.core_clk (core_clk),
		.resetn   (resetn),
		.pin_in   (test_mode),
		.level    (tms_s),
		.rise     (),
		.fall     ()
	);

	jtb_sync u_sync_tdi (
		.core_clk (core_clk),
		.resetn   (resetn),
		.pin_in   (test_din),
		.level    (tdi_s),
		.rise     (),
		.fall     ()
	);

	// ========================================================================
	// State
	// ========================================================================
	typedef struct packed {
		jtb_state_t         st;
		logic [IR_W-1:0]    ir_sh;
		logic [IR_W-1:0]    ir;
		logic [ID_W-1:0]    id_sh;
		logic               byp;
		logic [BSR_W-1:0]   bsr_sh;
		logic [OUT_W-1:0]   out_upd;
		logic               int_upd;
		logic               tdo;
		logic               tdo_oe;
		logic               tdo_pend;
		logic               oe_pend;
	} jtb_tap_t;

	jtb_tap_t s_r;
	jtb_tap_t s_nxt;

	// Next controller state; a single table serves both branches.
	function automatic jtb_state_t next_state(input jtb_state_t cur, input logic tms);
		unique case (cur)
			ST_TLR:   next_state = tms ? ST_TLR   : ST_RTI;
			ST_RTI:   next_state = tms ? ST_SELDR : ST_RTI;
			ST_SELDR: next_state = tms ? ST_SELIR : ST_CAPDR;
			ST_CAPDR: next_state = tms ? ST_EX1DR : ST_SHDR;
			ST_SHDR:  next_state = tms ? ST_EX1DR : ST_SHDR;
			ST_EX1DR: next_state = tms ? ST_UPDR  : ST_PSDR;
			ST_PSDR:  next_state = tms ? ST_EX2DR : ST_PSDR;
			ST_EX2DR: next_state = tms ? ST_UPDR  : ST_SHDR;
			ST_UPDR:  next_state = tms ? ST_SELDR : ST_RTI;
			ST_SELIR: next_state = tms ? ST_TLR   : ST_CAPIR;
			ST_CAPIR: next_state = tms ? ST_EX1IR : ST_SHIR;
			ST_SHIR:  next_state = tms ? ST_EX1IR : ST_SHIR;
			ST_EX1IR: next_state = tms ? ST_UPIR  : ST_PSIR;
			ST_PSIR:  next_state = tms ? ST_EX2IR : ST_PSIR;
			ST_EX2IR: next_state = tms ? ST_UPIR  : ST_SHIR;
			ST_UPIR:  next_state = tms ? ST_SELIR : ST_RTI;
			default:  next_state = ST_TLR;
		endcase
	endfunction : next_state

	// Instructions that route the boundary register.
	function automatic logic uses_bsr(input logic [IR_W-1:0] ins);
		uses_bsr = (ins == INS_EXTEST) || (ins == INS_SAMPLE_Z) || (ins == INS_SAMPLE);
	endfunction : uses_bsr

	logic        ext_test;
	logic        samp_z;
	logic [BSR_W-1:0] ring_snap;

	assign ext_test  = (s_r.ir == INS_EXTEST);
	assign samp_z    = (s_r.ir == INS_SAMPLE_Z);
	assign ring_snap = {1'b1, ring_in};

	// ========================================================================
	// Sequencing
	// ========================================================================
	always_comb begin
		s_nxt = s_r;
		if (tck_rise) begin
			// Five ones reach reset from any state through the graph itself.
			s_nxt.st = next_state(s_r.st, tms_s);
			unique case (s_r.st)
				ST_TLR: begin
					s_nxt.ir = IR_RESET_VAL;
				end
				ST_CAPIR: begin
					s_nxt.ir_sh = {1'b0, IR_CAPTURE};
				end
				ST_SHIR: begin
					s_nxt.ir_sh = {tdi_s, s_r.ir_sh[IR_W-1:1]};
				end
				ST_UPIR: begin
					s_nxt.ir = s_r.ir_sh;
				end
				ST_CAPDR: begin
					if (s_r.ir == INS_IDCODE) begin
						s_nxt.id_sh = ID_VALUE;
					end else if (uses_bsr(s_r.ir)) begin
						s_nxt.bsr_sh = ring_snap;
					end else begin
						s_nxt.byp = 1'b0;
					end
				end
				ST_SHDR: begin
					if (s_r.ir == INS_IDCODE) begin
						s_nxt.id_sh = {tdi_s, s_r.id_sh[ID_W-1:1]};
					end else if (uses_bsr(s_r.ir)) begin
						s_nxt.bsr_sh = {tdi_s, s_r.bsr_sh[BSR_W-1:1]};
					end else begin
						s_nxt.byp = tdi_s;
					end
				end
				ST_UPDR: begin
					if (ext_test) begin
						s_nxt.out_upd = s_r.bsr_sh[OUT_W-1:0];
						s_nxt.int_upd = s_r.bsr_sh[INT_CELL];
					end
				end
				default: begin
				end
			endcase
			// Entering reset must restore the identify code at once, not one edge later.
			if (s_nxt.st == ST_TLR) begin
				s_nxt.ir = IR_RESET_VAL;
			end
			// Output bit is chosen now, presented at the next falling edge.
			s_nxt.oe_pend = (s_r.st == ST_SHIR) || (s_r.st == ST_SHDR) ||
				(s_nxt.st == ST_SHIR) || (s_nxt.st == ST_SHDR);
			if (s_nxt.st == ST_SHIR) begin
				s_nxt.tdo_pend = s_nxt.ir_sh[0];
			end else if (s_nxt.ir == INS_IDCODE) begin
				s_nxt.tdo_pend = s_nxt.id_sh[0];
			end else if (uses_bsr(s_nxt.ir)) begin
				s_nxt.tdo_pend = s_nxt.bsr_sh[0];
			end else begin
				s_nxt.tdo_pend = s_nxt.byp;
			end
			s_nxt.oe_pend = (s_nxt.st == ST_SHIR) || (s_nxt.st == ST_SHDR);
		end
		if (tck_fall) begin
			s_nxt.tdo    = s_r.tdo_pend;
			s_nxt.tdo_oe = s_r.oe_pend;
		end
	end

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			s_r          <= '0;
			s_r.st       <= ST_TLR;
			s_r.ir       <= IR_RESET_VAL;
			s_r.ir_sh    <= IR_RESET_VAL;
			s_r.id_sh    <= ID_VALUE;
		end else begin
			s_r <= s_nxt;
		end
	end

	// ========================================================================
	// Pin muxing
	// ========================================================================
	// Every code other than external test and sample-Z leaves the functional path intact; sample-Z floats read_data_oe.
	always_comb begin
		read_data_output    = core_read_data;
		read_data_oe        = core_read_data_oe;
		read_valid_output   = core_read_valid;
		echo_clock_output   = core_echo_clock;
		echo_clock_output_n = core_echo_clock_n;
		if (ext_test) begin
			read_data_output    = s_r.out_upd[Q_LSB +: Q_W];
			read_valid_output   = s_r.out_upd[VLD_BIT];
			echo_clock_output   = s_r.out_upd[ECHO_BIT];
			echo_clock_output_n = s_r.out_upd[ECHON_BIT];
			read_data_oe        = s_r.int_upd;
		end else if (samp_z) begin
			read_data_oe = 1'b0;
		end
	end

	assign on_die_termination_en     = ~(ext_test | samp_z);
	assign test_dout                 = s_r.tdo;
	assign test_dout_oe              = s_r.tdo_oe;
	assign test_instruction_register = s_r.ir;
	assign test_reset_state          = (s_r.st == ST_TLR);

endmodule : jtb_tap

`default_nettype wire

// ===== tb/jtb_assertions.sv
`timescale 1ns/100ps
`default_nettype none
// ==========================================
// Port checks of the test access port.
module jtb_assertions
	import jtb_pkg::*;
(
	// Clocks and reset
	input wire logic            core_clk,
	input wire logic            resetn,
	input wire logic            test_clk,
	// Watched ports
	input wire logic            test_dout,
	input wire logic            test_dout_oe,
	input wire logic [Q_W-1:0]  core_read_data,
	input wire logic            core_read_data_oe,
	input wire logic [Q_W-1:0]  read_data_output,
	input wire logic            read_data_oe,
	input wire logic            on_die_termination_en,
	input wire logic [IR_W-1:0] test_instruction_register,
	input wire logic            test_reset_state
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!resetn);
	logic       clk_q_r;
	logic [3:0] since_r;
	logic       disturb;
	assign disturb = test_instruction_register == INS_EXTEST
		|| test_instruction_register == INS_SAMPLE_Z;
	// Counts core cycles since the last falling test clock edge.
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			clk_q_r <= 1'b0;
			since_r <= 4'hF;
		end else begin
			clk_q_r <= test_clk;
			if (clk_q_r && !test_clk) begin
				since_r <= 4'h0;
			end else if (since_r != 4'hF) begin
				since_r <= since_r + 4'h1;
			end
		end
	end
	odt_decode_a: assert property (on_die_termination_en == !disturb)
		else $error("termination enable wrong");
	float_z_a: assert property (test_instruction_register == INS_SAMPLE_Z |-> !read_data_oe)
		else $error("read drivers not floated");
	pass_thru_a: assert property (!disturb |-> read_data_output == core_read_data
		&& read_data_oe == core_read_data_oe) else $error("pins not passed through");
	reset_code_a: assert property (test_reset_state ##1 test_reset_state
		|-> test_instruction_register == IR_RESET_VAL) else $error("reset code lost");
	idle_float_a: assert property (test_reset_state |-> !test_dout_oe)
		else $error("data out driven in reset");
	ir_update_a: assert property (!$stable(test_instruction_register)
		|-> !test_dout_oe && !$past(test_dout_oe)) else $error("code changed in shift");
	ext_hold_a: assert property (test_instruction_register == INS_EXTEST
		&& $stable(test_instruction_register) && !$stable(read_data_output) |-> !test_dout_oe)
		else $error("pins changed while shifting");
	dout_edge_a: assert property ($changed(test_dout) || $changed(test_dout_oe)
		|-> since_r < 4'h7) else $error("data out moved away from falling edge");
	quiet_hold_a: assert property ($stable(test_clk) [*8] |-> $stable(test_reset_state)
		&& $stable(test_instruction_register)) else $error("state moved without clock");
endmodule : jtb_assertions
bind jtb_tap jtb_assertions jtb_assertions_inst (.core_clk(core_clk), .resetn(resetn),
	.test_clk(test_clk), .test_dout(test_dout), .test_dout_oe(test_dout_oe),
	.core_read_data(core_read_data), .core_read_data_oe(core_read_data_oe),
	.read_data_output(read_data_output), .read_data_oe(read_data_oe),
	.on_die_termination_en(on_die_termination_en),
	.test_instruction_register(test_instruction_register),
	.test_reset_state(test_reset_state));
`default_nettype wire

// ===== tb/jtb_tester.sv
`timescale 1ns/100ps
`default_nettype none
// ==========================================
// Outside tester; the test clock stays low between frames.
module jtb_tester (
	// Pacing clock
	input wire logic core_clk,
	// Test port
	output logic     test_clk,
	output logic     test_mode,
	output logic     test_din,
	input wire logic test_dout
);
	initial begin
		test_clk = 1'b0;
		test_mode = 1'b1;
		test_din = 1'b1;
	end
	task automatic tick(input logic tms, input logic tdi, output logic tdo);
		@(negedge core_clk);
		test_mode = tms;
		test_din = tdi;
		repeat (4) @(negedge core_clk);
		tdo = test_dout;
		test_clk = 1'b1;
		repeat (3) @(negedge core_clk);
		test_clk = 1'b0;
	endtask : tick
	// Runs one scan from idle back to idle.
	task automatic scan(input logic ir, input int n, input logic [128:0] din,
		output logic [128:0] dout);
		logic b;
		dout = '0;
		tick(1'b1, 1'b1, b);
		if (ir) tick(1'b1, 1'b1, b);
		tick(1'b0, 1'b1, b);
		tick(1'b0, 1'b1, b);
		for (int i = 0; i < n; i++) begin
			tick(i == n - 1, din[i], dout[i]);
		end
		tick(1'b1, 1'b1, b);
		tick(1'b0, 1'b1, b);
	endtask : scan
endmodule : jtb_tester
`default_nettype wire

// ===== tb/jtb_tap_tb.sv
`timescale 1ns/100ps
`default_nettype none
// ==========================================
// Scan-level tests of the test access port.
module jtb_tap_tb
	import jtb_pkg::*;
;
	logic              core_clk = 1'b0;
	logic              resetn = 1'b0;
	logic              test_clk, test_mode, test_din, test_dout, test_dout_oe, b;
	logic [RING_W-1:0] ring_in = {4{32'hC3A5_0F96}};
	logic [Q_W-1:0]    core_read_data = 36'h9_1234_5678;
	logic              core_read_data_oe = 1'b1;
	logic              core_read_valid = 1'b1;
	logic              core_echo_clock = 1'b0;
	logic              core_echo_clock_n = 1'b1;
	logic [Q_W-1:0]    read_data_output;
	logic              read_data_oe, read_valid_output, echo_clock_output, echo_clock_output_n;
	logic              on_die_termination_en, test_reset_state;
	logic [IR_W-1:0]   test_instruction_register;
	logic [128:0]      so, pat;
	int                n_fail = 0;
	int                check_count = 0;
	always #25 core_clk = ~core_clk;
	jtb_tap jtb_tap_inst (.core_clk(core_clk), .resetn(resetn), .test_clk(test_clk),
		.test_mode(test_mode), .test_din(test_din), .test_dout(test_dout),
		.test_dout_oe(test_dout_oe), .ring_in(ring_in), .core_read_data(core_read_data),
		.core_read_data_oe(core_read_data_oe), .core_read_valid(core_read_valid),
		.core_echo_clock(core_echo_clock), .core_echo_clock_n(core_echo_clock_n),
		.read_data_output(read_data_output), .read_data_oe(read_data_oe),
		.read_valid_output(read_valid_output), .echo_clock_output(echo_clock_output),
		.echo_clock_output_n(echo_clock_output_n),
		.on_die_termination_en(on_die_termination_en),
		.test_instruction_register(test_instruction_register),
		.test_reset_state(test_reset_state));
	jtb_tester jtb_tester_inst (.core_clk(core_clk), .test_clk(test_clk),
		.test_mode(test_mode), .test_din(test_din), .test_dout(test_dout));
	task automatic check(input string name, input logic [128:0] seen, input logic [128:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_fail++;
			$display("unexpected %s expected %h seen %h", name, exp, seen);
		end
	endtask : check
	task automatic finish_test();
		$display("checks %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : finish_test
	task automatic set_ir(input logic [2:0] code);
		jtb_tester_inst.scan(1'b1, IR_W, {126'h0, code}, so);
		check("captured code", so[2:0], 3'h1);
		check("instruction", test_instruction_register, code);
	endtask : set_ir
	initial begin
		#1_000_000;
		n_fail++;
		finish_test();
	end
	initial begin
		repeat (16) @(negedge core_clk);
		resetn = 1'b1;
		repeat (4) @(negedge core_clk);
		check("reset state", test_reset_state, 1'b1);
		check("reset code", test_instruction_register, IR_RESET_VAL);
		check("dout idle", test_dout_oe, 1'b0);
		jtb_tester_inst.tick(1'b0, 1'b1, b);
		jtb_tester_inst.scan(1'b0, ID_W, '0, so);
		check("identity", so[ID_W-1:0], ID_VALUE);
		// Five ones from Shift-DR are the fewest that reach reset.
		set_ir(INS_BYPASS);
		jtb_tester_inst.tick(1'b1, 1'b1, b);
		jtb_tester_inst.tick(1'b0, 1'b1, b);
		jtb_tester_inst.tick(1'b0, 1'b1, b);
		repeat (4) jtb_tester_inst.tick(1'b1, 1'b1, b);
		check("early reset", test_reset_state, 1'b0);
		jtb_tester_inst.tick(1'b1, 1'b1, b);
		repeat (4) @(negedge core_clk);
		check("five ones", test_reset_state, 1'b1);
		check("code in reset", test_instruction_register, IR_RESET_VAL);
		jtb_tester_inst.tick(1'b0, 1'b1, b);
		for (int c = 1; c < 8; c++) begin
			set_ir(3'(c));
			check("termination", on_die_termination_en, c != 2);
			if (c == 2) check("float", read_data_oe, 1'b0);
			if (c != 2) check("pass data", read_data_output, core_read_data);
			if (c == 7) begin
				jtb_tester_inst.scan(1'b0, 8, 129'h00A5, so);
				check("bypass", so[7:0], 8'h4A);
			end
			if (c == 2 || c == 4) begin
				jtb_tester_inst.scan(1'b0, BSR_W, '1, so);
				check("boundary", so, {1'b1, ring_in});
			end
		end
		set_ir(INS_EXTEST);
		check("termination", on_die_termination_en, 1'b0);
		for (int k = 0; k < 2; k++) begin
			pat = '0;
			pat[35:0] = 36'hA_5A5A_5A5A;
			pat[38:36] = 3'h5;
			pat[128] = (k == 0);
			jtb_tester_inst.scan(1'b0, BSR_W, pat, so);
			check("ext capture", so, {1'b1, ring_in});
			check("ext data", read_data_output, pat[35:0]);
			check("ext ctl", {echo_clock_output_n, echo_clock_output, read_valid_output},
				pat[38:36]);
			check("ext enable", read_data_oe, pat[128]);
		end
		finish_test();
	end
endmodule : jtb_tap_tb
`default_nettype wire
